// ---- hw/wfl_pkg.sv ----
// Shared constants for the watchdog, fault log and lock block
`default_nettype none
package wfl_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] WATCHDOG_ONE_TIMEOUT_CFG_ADDR   = 8'h3d;
    localparam logic [7:0] WATCHDOG_TWO_TIMEOUT_CFG_ADDR   = 8'h3f;
    localparam logic [7:0] USER_WRITE_DISABLE_ADDR         = 8'h43;
    localparam logic [7:0] CONFIG_LOCK_ADDR                = 8'h45;
    localparam logic [7:0] PRIMARY_THRESHOLD_FAULTS_ADDR   = 8'h60;
    localparam logic [7:0] SECONDARY_THRESHOLD_FAULTS_ADDR = 8'h61;
    localparam logic [7:0] INPUT_EVENT_FAULTS_ADDR         = 8'h62;

    // ------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------
    localparam int NORMAL_PERIOD_LSB  = 0;
    localparam int INITIAL_PERIOD_LSB = 3;
    localparam int PERIOD_CODE_W      = 3;
    localparam int WATCHDOG_EN_BIT    = 6;
    localparam logic [7:0] TIMEOUT_CFG_MASK = 8'h7f;
    localparam logic [7:0] LOCK_MASK        = 8'h01;
    localparam int LOCK_BIT               = 0;
    localparam int DETECTOR_COUNT         = 6;
    localparam int GENERAL_INPUT_COUNT    = 4;
    localparam int EVENT_FLAG_COUNT       = 7;
    localparam int EVENT_WDT_ONE_BIT      = 0;
    localparam int EVENT_WDT_TWO_BIT      = 1;
    localparam int EVENT_GENERAL_INPUT_LSB = 2;
    localparam int EVENT_MANUAL_RESET_BIT = 6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TIMEOUT_CFG_RESET   = 8'h00;
    localparam logic [7:0] WRITE_DISABLE_RESET = 8'h00;
    localparam logic [7:0] LOCK_RESET          = 8'h00;
    localparam logic [7:0] UNMAPPED_READ       = 8'h00;

    // ------------------------------------------------------------------
    // Timing: shortest period 6.25 ms, each code step is four times longer
    // ------------------------------------------------------------------
    localparam longint CLK_PERIOD_PS    = 10000;
    localparam longint BASE_TIMEOUT_PS  = 64'd6250000000;
    localparam longint BASE_TIMEOUT_CYC = BASE_TIMEOUT_PS / CLK_PERIOD_PS;
    localparam int     TIMER_W          = 36;
endpackage : wfl_pkg
`default_nettype wire

// ---- hw/wfl_sticky_flags.sv ----
// Sticky fault flags, set by events and cleared as a group
`timescale 1ns/1ps
`default_nettype none
module wfl_sticky_flags #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] set,
    input  wire logic         clear,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } wfl_flag_state_t;

    wfl_flag_state_t state;
    wfl_flag_state_t next_state;

    // Set beats clear so an event landing on the read is kept
    always_comb
    begin
        next_state = state;
        if (clear)
        begin
            next_state.flags = '0;
        end
        next_state.flags = next_state.flags | set;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign flags = state.flags;

    flag_kept_a: assert property (@(posedge mclk) disable iff (reset)
        (|set) |=> ((flags & $past(set)) == $past(set)))
        else $error("set flag lost");
endmodule : wfl_sticky_flags
`default_nettype wire

// ---- hw/wfl_watchdog.sv ----
// One watchdog timer with initial and normal timeout periods
`timescale 1ns/1ps
`default_nettype none
module wfl_watchdog #(
    parameter logic [35:0] BASE_CYCLES = 36'd625000
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [7:0] cfg,
    input  wire logic       kick,
    output logic            fault
);
    typedef struct packed {
        logic [wfl_pkg::TIMER_W-1:0] count;
        logic                        use_initial;
        logic                        enabled;
        logic                        kick_seen;
        logic                        fault;
    } wfl_wdt_state_t;

    wfl_wdt_state_t              state;
    wfl_wdt_state_t              next_state;
    logic [2:0]                  code;
    logic [wfl_pkg::TIMER_W-1:0] limit;
    logic                        enable;

    assign enable = cfg[wfl_pkg::WATCHDOG_EN_BIT];
    // Each code is four times the previous period
    assign code = state.use_initial
                ? cfg[wfl_pkg::INITIAL_PERIOD_LSB +: wfl_pkg::PERIOD_CODE_W]
                : cfg[wfl_pkg::NORMAL_PERIOD_LSB +: wfl_pkg::PERIOD_CODE_W];
    assign limit = BASE_CYCLES << {code, 1'b0};

    always_comb
    begin
        next_state           = state;
        next_state.fault     = 1'b0;
        next_state.enabled   = enable;
        next_state.kick_seen = kick;
        if (!enable)
        begin
            next_state.count       = '0;
            next_state.use_initial = 1'b1;
        end
        else if (!state.enabled)
        begin
            next_state.count       = '0;
            next_state.use_initial = 1'b1;
        end
        else if (kick != state.kick_seen)
        begin
            next_state.count       = '0;
            next_state.use_initial = 1'b0;
        end
        else if (state.count >= limit - 36'd1)
        begin
            next_state.count       = '0;
            next_state.use_initial = 1'b0;
            next_state.fault       = 1'b1;
        end
        else
        begin
            next_state.count = state.count + 36'd1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= '{count: '0, use_initial: 1'b1, enabled: 1'b0,
                       kick_seen: 1'b0, fault: 1'b0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign fault = state.fault;

    wdt_disabled_quiet_a: assert property (@(posedge mclk) disable iff (reset)
        !enable |=> !fault)
        else $error("disabled watchdog faulted");
    wdt_period_exact_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(fault) |-> $past(state.count) == $past(limit) - 36'd1)
        else $error("timeout not at programmed period");
endmodule : wfl_watchdog
`default_nettype wire

// ---- hw/wfl_top.sv ----
// Watchdog configuration, fault log and configuration lock registers
//
// Operation
// - Timeout bits 2:0 pick normal period, 6.25 ms up to 102.4 s.
// - Bits 5:3 pick initial period used after reset or enabling.
// - Bit 6 enables the watchdog; bit 7 has no function.
// - Watchdog one configured at 3Dh, watchdog two at 3Fh.
// - Register 60h bits 0-5 flag primary undervoltage per detector.
// - Register 61h bits 0-5 flag secondary threshold crossings.
// - Watchdog fault on a general input also sets that input's flag.
// - Register 45h bit 0 is the configuration lock.
// - Locked: config register and config EEPROM writes refused, lock excepted.
// - User EEPROM writes blocked while an output enabled in 43h is asserted.
// - Any fault register read clears all fault flags.
// - After the initial period, normal period applies every cycle.
// - Register 43h bits block user EEPROM writes per asserted output.
`timescale 1ns/1ps
`default_nettype none
module wfl_top #(
    parameter logic [35:0] WDT_BASE_CYCLES =
        36'(wfl_pkg::BASE_TIMEOUT_CYC)
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_wr_refused,
    input  wire logic       watchdog_kick_one,
    input  wire logic       watchdog_kick_two,
    input  wire logic [1:0] watchdog_kick_from_input,
    input  wire logic [3:0] watchdog_kick_input_sel,
    input  wire logic [5:0] primary_undervoltage,
    input  wire logic [5:0] secondary_threshold_trip,
    input  wire logic [3:0] general_input,
    input  wire logic       manual_reset_input,
    input  wire logic [7:0] programmable_output,
    input  wire logic       cfg_eeprom_wr_req,
    output logic            cfg_eeprom_wr_allow,
    input  wire logic       user_eeprom_wr_req,
    output logic            user_eeprom_wr_allow,
    output logic            watchdog_fault_one,
    output logic            watchdog_fault_two
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] wdt_one_cfg;
        logic [7:0] wdt_two_cfg;
        logic [7:0] write_disable;
        logic [7:0] lock;
        logic [7:0] rdata;
    } wfl_top_state_t;

    wfl_top_state_t state;
    wfl_top_state_t next_state;

    logic                                   fault_read;
    logic                                   cfg_write;
    logic                                   locked;
    logic [wfl_pkg::DETECTOR_COUNT-1:0]     primary_flags;
    logic [wfl_pkg::DETECTOR_COUNT-1:0]     secondary_flags;
    logic [wfl_pkg::EVENT_FLAG_COUNT-1:0]   event_flags;
    logic [wfl_pkg::EVENT_FLAG_COUNT-1:0]   event_set;
    logic [wfl_pkg::GENERAL_INPUT_COUNT-1:0] input_from_wdt;
    logic [7:0]                             read_mux;

    assign locked = state.lock[wfl_pkg::LOCK_BIT];

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    assign fault_read = reg_rd &&
        (reg_addr == wfl_pkg::PRIMARY_THRESHOLD_FAULTS_ADDR ||
         reg_addr == wfl_pkg::SECONDARY_THRESHOLD_FAULTS_ADDR ||
         reg_addr == wfl_pkg::INPUT_EVENT_FAULTS_ADDR);

    assign cfg_write = reg_wr &&
        (reg_addr == wfl_pkg::WATCHDOG_ONE_TIMEOUT_CFG_ADDR ||
         reg_addr == wfl_pkg::WATCHDOG_TWO_TIMEOUT_CFG_ADDR ||
         reg_addr == wfl_pkg::USER_WRITE_DISABLE_ADDR);

    // Refusal is visible so the host can tell a locked write
    assign reg_wr_refused = cfg_write && locked;

    always_comb
    begin
        read_mux = wfl_pkg::UNMAPPED_READ;
        case (reg_addr)
            wfl_pkg::WATCHDOG_ONE_TIMEOUT_CFG_ADDR:
                read_mux = state.wdt_one_cfg;
            wfl_pkg::WATCHDOG_TWO_TIMEOUT_CFG_ADDR:
                read_mux = state.wdt_two_cfg;
            wfl_pkg::USER_WRITE_DISABLE_ADDR:
                read_mux = state.write_disable;
            wfl_pkg::CONFIG_LOCK_ADDR:
                read_mux = state.lock;
            wfl_pkg::PRIMARY_THRESHOLD_FAULTS_ADDR:
                read_mux = {2'h0, primary_flags};
            wfl_pkg::SECONDARY_THRESHOLD_FAULTS_ADDR:
                read_mux = {2'h0, secondary_flags};
            wfl_pkg::INPUT_EVENT_FAULTS_ADDR:
                read_mux = {1'h0, event_flags};
            default:
                read_mux = wfl_pkg::UNMAPPED_READ;
        endcase
    end

    always_comb
    begin
        next_state = state;
        if (reg_rd)
        begin
            next_state.rdata = read_mux;
        end
        if (reg_wr && !locked)
        begin
            case (reg_addr)
                wfl_pkg::WATCHDOG_ONE_TIMEOUT_CFG_ADDR:
                    next_state.wdt_one_cfg =
                        reg_wdata & wfl_pkg::TIMEOUT_CFG_MASK;
                wfl_pkg::WATCHDOG_TWO_TIMEOUT_CFG_ADDR:
                    next_state.wdt_two_cfg =
                        reg_wdata & wfl_pkg::TIMEOUT_CFG_MASK;
                wfl_pkg::USER_WRITE_DISABLE_ADDR:
                    next_state.write_disable = reg_wdata;
                default:
                    next_state.write_disable = state.write_disable;
            endcase
        end
        // Lock register stays writable so a locked part can be opened
        if (reg_wr && reg_addr == wfl_pkg::CONFIG_LOCK_ADDR)
        begin
            next_state.lock = reg_wdata & wfl_pkg::LOCK_MASK;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= '{wdt_one_cfg:   wfl_pkg::TIMEOUT_CFG_RESET,
                       wdt_two_cfg:   wfl_pkg::TIMEOUT_CFG_RESET,
                       write_disable: wfl_pkg::WRITE_DISABLE_RESET,
                       lock:          wfl_pkg::LOCK_RESET,
                       rdata:         8'h00};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;

    // ------------------------------------------------------------------
    // EEPROM write gating
    // ------------------------------------------------------------------
    assign cfg_eeprom_wr_allow = cfg_eeprom_wr_req && !locked;
    // Falling supplies assert outputs; those outputs fence the EEPROM
    assign user_eeprom_wr_allow = user_eeprom_wr_req &&
        !(|(state.write_disable & programmable_output));

    // ------------------------------------------------------------------
    // Watchdogs
    // ------------------------------------------------------------------
    wfl_watchdog #(
        .BASE_CYCLES (WDT_BASE_CYCLES)
    ) u_wdt_one (
        .mclk  (mclk),
        .reset (reset),
        .cfg   (state.wdt_one_cfg),
        .kick  (watchdog_kick_one),
        .fault (watchdog_fault_one)
    );

    wfl_watchdog #(
        .BASE_CYCLES (WDT_BASE_CYCLES)
    ) u_wdt_two (
        .mclk  (mclk),
        .reset (reset),
        .cfg   (state.wdt_two_cfg),
        .kick  (watchdog_kick_two),
        .fault (watchdog_fault_two)
    );

    // ------------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------------
    always_comb
    begin
        input_from_wdt = '0;
        if (watchdog_fault_one && watchdog_kick_from_input[0])
        begin
            input_from_wdt[watchdog_kick_input_sel[1:0]] = 1'b1;
        end
        if (watchdog_fault_two && watchdog_kick_from_input[1])
        begin
            input_from_wdt[watchdog_kick_input_sel[3:2]] = 1'b1;
        end
    end

    assign event_set = {manual_reset_input,
                        general_input | input_from_wdt,
                        watchdog_fault_two,
                        watchdog_fault_one};

    wfl_sticky_flags #(
        .W (wfl_pkg::DETECTOR_COUNT)
    ) u_primary_flags (
        .mclk  (mclk),
        .reset (reset),
        .set   (primary_undervoltage),
        .clear (fault_read),
        .flags (primary_flags)
    );

    wfl_sticky_flags #(
        .W (wfl_pkg::DETECTOR_COUNT)
    ) u_secondary_flags (
        .mclk  (mclk),
        .reset (reset),
        .set   (secondary_threshold_trip),
        .clear (fault_read),
        .flags (secondary_flags)
    );

    wfl_sticky_flags #(
        .W (wfl_pkg::EVENT_FLAG_COUNT)
    ) u_event_flags (
        .mclk  (mclk),
        .reset (reset),
        .set   (event_set),
        .clear (fault_read),
        .flags (event_flags)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    locked_cfg_hold_a: assert property (
        locked && reg_wr && reg_addr == wfl_pkg::WATCHDOG_ONE_TIMEOUT_CFG_ADDR
        |=> $stable(state.wdt_one_cfg))
        else $error("locked write changed configuration");
    lock_writable_a: assert property (
        reg_wr && reg_addr == wfl_pkg::CONFIG_LOCK_ADDR
        |=> locked == $past(reg_wdata[0]))
        else $error("lock bit not written");
    unused_bits_zero_a: assert property (
        !state.wdt_one_cfg[7] && !state.wdt_two_cfg[7]
        && state.lock[7:1] == 7'h00)
        else $error("unused bit set");
    read_clears_all_a: assert property (
        fault_read && !(|primary_undervoltage) && !(|event_set)
        && !(|secondary_threshold_trip)
        |=> primary_flags == '0 && secondary_flags == '0
            && event_flags == '0)
        else $error("fault read did not clear flags");
    flag_holds_a: assert property (
        primary_flags[0] && !fault_read |=> primary_flags[0])
        else $error("primary flag dropped without read");
    primary_latch_a: assert property (
        primary_undervoltage[0] |=> primary_flags[0])
        else $error("primary undervoltage not flagged");
    manual_reset_flag_a: assert property (
        manual_reset_input |=> event_flags[wfl_pkg::EVENT_MANUAL_RESET_BIT])
        else $error("manual reset not flagged");
    wdt_input_pair_a: assert property (
        watchdog_fault_one && watchdog_kick_from_input[0]
        |=> event_flags[wfl_pkg::EVENT_WDT_ONE_BIT]
            && event_flags[wfl_pkg::EVENT_GENERAL_INPUT_LSB
                           + $past(watchdog_kick_input_sel[1:0])])
        else $error("watchdog fault missing input flag");
    user_ee_fence_a: assert property (
        |(state.write_disable & programmable_output) |-> !user_eeprom_wr_allow)
        else $error("user EEPROM write not blocked");
    cfg_ee_fence_a: assert property (
        locked |-> !cfg_eeprom_wr_allow)
        else $error("config EEPROM write while locked");

    wdt_fault_seen_c: cover property (watchdog_fault_one ##1 fault_read);
    locked_refusal_c: cover property (locked && reg_wr_refused);
    read_after_set_c: cover property (manual_reset_input ##2 fault_read);
endmodule : wfl_top
`default_nettype wire

// ---- verification/wfl_host.sv ----
// Host model driving the byte-level register port of the block
`timescale 1ns/1ps
`default_nettype none
module wfl_host (
    input  wire logic       mclk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_wr_refused
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // --------------------------------------------------------------
    // Byte transfers
    // --------------------------------------------------------------
    // Released lines flip, so a stale value never passes for a match
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic refused);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        #1 refused = reg_wr_refused;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        // Let the write land before the caller looks at its effect
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
endmodule // wfl_host
`default_nettype wire

// ---- verification/test_watchdog_fault_log_lock.sv ----
// Self-checking bench for the watchdog, fault log and lock block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_fault_log_lock;
    localparam logic [35:0] BASE = 36'd4;
    logic mclk, reset, reg_wr, reg_rd, refused, kick_one, kick_two;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, prog_out;
    logic [5:0] pri, sec;
    logic [3:0] gen_in, kick_sel;
    logic [1:0] kick_src;
    logic man_rst, refd, cfg_req, cfg_allow, usr_req, usr_allow, f_one, f_two;
    int fails, checks, n, bad;

    wfl_top #(.WDT_BASE_CYCLES(BASE)) dut (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_wr_refused(refd),
        .watchdog_kick_one(kick_one), .watchdog_kick_two(kick_two),
        .watchdog_kick_from_input(kick_src),
        .watchdog_kick_input_sel(kick_sel),
        .primary_undervoltage(pri), .secondary_threshold_trip(sec),
        .general_input(gen_in), .manual_reset_input(man_rst),
        .programmable_output(prog_out), .cfg_eeprom_wr_req(cfg_req),
        .cfg_eeprom_wr_allow(cfg_allow), .user_eeprom_wr_req(usr_req),
        .user_eeprom_wr_allow(usr_allow), .watchdog_fault_one(f_one),
        .watchdog_fault_two(f_two));
    wfl_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_wr_refused(refd));

    always #5 mclk = ~mclk;

    // --------------------------------------------------------------
    // Shared helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask

    // Cycles until the chosen fault pulse, -1 if none within lim
    task automatic wait_fault(input logic two, input int lim);
        n = -1;
        for (int i = 1; i <= lim && n < 0; i++)
        begin
            @(posedge mclk);
            #1;
            if ((two ? f_two : f_one) === 1'b1)
                n = i;
        end
    endtask

    task automatic in_range(input int lo, input int hi);
        chk({7'h00, n >= lo && n <= hi}, 8'h01);
        if (n < 0)
            stop_test();
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        host.rd(8'h60, d);
        rdchk(8'h3d, 8'h00);
        rdchk(8'h3f, 8'h00);
        rdchk(8'h43, 8'h00);
        rdchk(8'h45, 8'h00);
        host.wr(8'h50, 8'h5a, refused);
        rdchk(8'h50, 8'h00);
        $display("done reset values");
    endtask

    task automatic t_regs();
        host.wr(8'h3d, 8'hff, refused);
        rdchk(8'h3d, 8'h7f);
        host.wr(8'h3f, 8'h80, refused);
        rdchk(8'h3f, 8'h00);
        host.wr(8'h43, 8'ha5, refused);
        rdchk(8'h43, 8'ha5);
        host.wr(8'h45, 8'hfe, refused);
        rdchk(8'h45, 8'h00);
        host.wr(8'h61, 8'hff, refused);
        rdchk(8'h61, 8'h00);
        $display("done register access");
    endtask

    task automatic t_lock();
        @(posedge mclk);
        cfg_req <= 1'b1;
        host.wr(8'h45, 8'hff, refused);
        rdchk(8'h45, 8'h01);
        chk({7'h00, cfg_allow}, 8'h00);
        host.wr(8'h3d, 8'h12, refused);
        chk({7'h00, refused}, 8'h01);
        host.wr(8'h43, 8'h00, refused);
        chk({7'h00, refused}, 8'h01);
        rdchk(8'h3d, 8'h7f);
        rdchk(8'h43, 8'ha5);
        // Host drops the lock before touching the configuration
        host.wr(8'h45, 8'h00, refused);
        chk({7'h00, refused}, 8'h00);
        chk({7'h00, cfg_allow}, 8'h01);
        host.wr(8'h3d, 8'h00, refused);
        rdchk(8'h3d, 8'h00);
        @(posedge mclk);
        cfg_req <= 1'b0;
        $display("done configuration lock");
    endtask

    task automatic t_faults();
        logic [7:0] exp [3];
        exp = '{8'h21, 8'h12, 8'h64};
        for (int i = 0; i < 3; i++)
        begin
            @(posedge mclk);
            pri <= 6'h21;
            sec <= 6'h12;
            gen_in <= 4'h9;
            man_rst <= 1'b1;
            @(posedge mclk);
            pri <= 6'h00;
            sec <= 6'h00;
            gen_in <= 4'h0;
            man_rst <= 1'b0;
            repeat (3) @(posedge mclk);
            rdchk(8'h60 + 8'(i), exp[i]);
            rdchk(8'h60 + 8'((i + 1) % 3), 8'h00);
        end
        $display("done fault flags");
    endtask

    task automatic t_wdt_one();
        @(posedge mclk);
        kick_src <= 2'b01;
        kick_sel <= 4'h2;
        // Initial code 0 and normal code 1 tell the two fields apart
        host.wr(8'h3d, 8'h41, refused);
        wait_fault(1'b0, 40);
        in_range(2, 6);
        wait_fault(1'b0, 40);
        in_range(14, 18);
        host.wr(8'h3d, 8'h01, refused);
        rdchk(8'h62, 8'h11);
        wait_fault(1'b0, 60);
        chk(8'(n), 8'hff);
        @(posedge mclk);
        kick_src <= 2'b00;
        $display("done watchdog one");
    endtask

    task automatic t_wdt_two();
        bad = 0;
        // Watchdog two kicked from general input 3
        @(posedge mclk);
        kick_src <= 2'b10;
        kick_sel <= 4'hc;
        host.wr(8'h3f, 8'h40, refused);
        for (int i = 0; i < 30; i++)
        begin
            @(posedge mclk);
            if (i % 2 == 0)
                kick_two <= ~kick_two;
            #1;
            if (f_two !== 1'b0 || f_one !== 1'b0)
                bad++;
        end
        chk(8'(bad), 8'h00);
        wait_fault(1'b1, 40);
        in_range(2, 7);
        host.wr(8'h3f, 8'h00, refused);
        rdchk(8'h62, 8'h22);
        @(posedge mclk);
        kick_src <= 2'b00;
        $display("done watchdog two");
    endtask

    task automatic t_wr_disable();
        host.wr(8'h43, 8'h01, refused);
        @(posedge mclk);
        usr_req <= 1'b1;
        prog_out <= 8'h01;
        @(posedge mclk);
        #1 chk({7'h00, usr_allow}, 8'h00);
        @(posedge mclk);
        prog_out <= 8'h02;
        @(posedge mclk);
        #1 chk({7'h00, usr_allow}, 8'h01);
        @(posedge mclk);
        usr_req <= 1'b0;
        $display("done write disable");
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        reset = 1'b1;
        {kick_one, kick_two, man_rst, cfg_req, usr_req} = 5'h00;
        {pri, sec, gen_in, kick_sel, kick_src, prog_out} = 30'h0;
        fails = 0;
        checks = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_lock();
        t_faults();
        t_wdt_one();
        t_wdt_two();
        t_wr_disable();
        stop_test();
    end
endmodule // test_watchdog_fault_log_lock
`default_nettype wire
